// >>> inc/mrcw_map.vh
// Register map, reset values and timing constants of the reset, clock and watchdog block
`ifndef MRCW_MAP_VH
`define MRCW_MAP_VH
`define MRCW_ADDR_WDOG 8'hD8
`define MRCW_ADDR_STATUS 8'hDC
`define MRCW_WDOG_RESET 8'hFE
`define MRCW_WDOG_CNT_RST 7'h7F
`define MRCW_BIT_ACT 0
`define MRCW_BIT_SWRST 1
`define MRCW_CORE_DIV 4'hD
`define MRCW_WDOG_DIV 4'hC
`define MRCW_STAB_CYCLES 12'h800
`define MRCW_RESET_VECTOR 12'hFFE
`define MRCW_TIMER_CTRL_RST 8'h00
`define MRCW_TIMER_CNT_RST 8'hFF
`define MRCW_TIMER_PRE_RST 7'h7F
`define MRCW_OSC_START_CYCLES 8'h10
`endif

// >>> hdl/mrcw_divider.v
// Divide-by-N enable pulse generator
`timescale 1ns/10ps
module mrcw_divider (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Control
	input wire run,
	input wire [3:0] divisor,
	// Pulse out
	output reg tick
);
	reg [3:0] count_reg;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= 4'h0;
			tick <= 1'b0;
		end else if (!run) begin
			count_reg <= 4'h0;
			tick <= 1'b0;
		end else if (count_reg == divisor - 4'h1) begin
			count_reg <= 4'h0;
			tick <= 1'b1;
		end else begin
			count_reg <= count_reg + 4'h1;
			tick <= 1'b0;
		end
	end
endmodule // mrcw_divider

// >>> hdl/mrcw_sync.v
// Two-flop synchroniser for a level
`timescale 1ns/10ps
module mrcw_sync (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Level
	input wire din,
	output reg dout
);
	reg meta;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // mrcw_sync

// >>> hdl/mrcw_reset_clock_watchdog.v
// Reset sequencer, clock dividers, watchdog and APB register slave
`timescale 1ns/10ps
`include "mrcw_map.vh"
module mrcw_reset_clock_watchdog (
	// Clock and power-on reset
	input wire clk,
	input wire rst_b,
	// Reset pin and option
	input wire resetPin_b,
	input wire hwWatchdogOpt,
	// Core status
	input wire stopRequest,
	input wire waitRequest,
	input wire wakeInterrupt,
	input wire coreMachineCycleDone,
	input wire returnFromInterrupt,
	input wire interruptPending,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Clock enables
	output reg coreTick,
	output reg wdogTick,
	// Reset outputs
	output reg coreReset,
	output reg ioPullupInputs,
	output reg oscRun,
	output reg stackClear,
	output reg [11:0] pcLoad,
	output reg nmiContext,
	output reg serviceInterrupt,
	output reg stopMode,
	output reg [7:0] timerCtrl,
	output reg [7:0] timerCount,
	output reg [6:0] timerPrescale
);
	localparam ST_OSC = 2'h0;
	localparam ST_HOLD = 2'h1;
	localparam ST_STAB = 2'h2;
	localparam ST_RUN = 2'h3;

	// Counter bits sit reversed in the register
	function [5:0] mrcw_reverse6;
		input [5:0] v;
		integer i;
		begin
			for (i = 0; i < 6; i = i + 1)
				mrcw_reverse6[i] = v[5 - i];
		end
	endfunction

	function mrcw_hit;
		input [7:0] a;
		input [7:0] match;
		begin
			mrcw_hit = (a == match);
		end
	endfunction

	wire pinLow;
	wire pinSync;
	wire coreTickW;
	wire wdogTickW;
	reg [1:0] state_reg;
	reg [11:0] stab_reg;
	reg [7:0] osc_reg;
	reg [6:0] wdCount_reg;
	reg wdActive_reg;
	reg wdFire_reg;
	reg wrPending_reg;
	reg [6:0] wrValue_reg;
	reg [1:0] state_next;
	reg [6:0] wdCount_next;

	mrcw_sync uPinSync (
		.clk(clk),
		.rst_b(rst_b),
		.din(resetPin_b),
		.dout(pinSync)
	);
	assign pinLow = ~pinSync;

	mrcw_divider uCoreDiv (
		.clk(clk),
		.rst_b(rst_b),
		.run(oscRun),
		.divisor(`MRCW_CORE_DIV),
		.tick(coreTickW)
	);
	mrcw_divider uWdogDiv (
		.clk(clk),
		.rst_b(rst_b),
		.run(oscRun),
		.divisor(`MRCW_WDOG_DIV),
		.tick(wdogTickW)
	);

	wire apbAccess = psel & penable & ~pready;
	wire hitWdog = mrcw_hit(paddr, `MRCW_ADDR_WDOG);
	wire hitStat = mrcw_hit(paddr, `MRCW_ADDR_STATUS);
	wire wdWrite = apbAccess & pwrite & hitWdog & (state_reg == ST_RUN);
	wire wdEnabled = wdActive_reg | hwWatchdogOpt;
	// Activate bit reads high whenever the hardware option forces it on
	wire [7:0] wdRegView = {mrcw_reverse6(wdCount_reg[5:0]), wdCount_reg[6],
		wdEnabled};
	wire [5:0] wrCounter = mrcw_reverse6(pwdata[7:2]);
	wire anyReset = pinLow | wdFire_reg;

	// Reset sequencer
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_OSC: if (osc_reg == `MRCW_OSC_START_CYCLES)
				state_next = pinLow ? ST_HOLD : ST_STAB;
			ST_HOLD: if (!pinLow)
				state_next = ST_STAB;
			ST_STAB: if (pinLow)
				state_next = ST_HOLD;
			else if (stab_reg == `MRCW_STAB_CYCLES - 12'h1)
				state_next = ST_RUN;
			ST_RUN: if (anyReset)
				state_next = ST_HOLD;
			default: state_next = ST_OSC;
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_OSC;
			stab_reg <= 12'h000;
			osc_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_OSC)
				osc_reg <= osc_reg + 8'h01;
			if (state_reg == ST_STAB && state_next == ST_STAB)
				stab_reg <= stab_reg + 12'h001;
			else
				stab_reg <= 12'h000;
		end
	end

	// Watchdog counter
	always @* begin
		wdCount_next = wdCount_reg;
		if (wdogTickW) begin
			if (wrPending_reg)
				wdCount_next = wrValue_reg;
			else
				wdCount_next = wdCount_reg - 7'h01;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdCount_reg <= `MRCW_WDOG_CNT_RST;
			wdActive_reg <= 1'b0;
			wdFire_reg <= 1'b0;
			wrPending_reg <= 1'b0;
			wrValue_reg <= `MRCW_WDOG_CNT_RST;
		end else if (state_reg != ST_RUN) begin
			wdCount_reg <= `MRCW_WDOG_CNT_RST;
			wdActive_reg <= 1'b0;
			wdFire_reg <= 1'b0;
			wrPending_reg <= 1'b0;
		end else begin
			if (wdWrite && pwdata[`MRCW_BIT_ACT])
				wdActive_reg <= 1'b1;
			if (wdWrite) begin
				wrPending_reg <= 1'b1;
				wrValue_reg <= {pwdata[`MRCW_BIT_SWRST], wrCounter};
			end else if (wdogTickW)
				wrPending_reg <= 1'b0;
			if (!stopMode || hwWatchdogOpt)
				wdCount_reg <= wdCount_next;
			// Software reset bit cleared by write or underflow
			if (wdWrite && !pwdata[`MRCW_BIT_SWRST])
				wdFire_reg <= 1'b1;
			else if (wdEnabled && wdCount_reg[6] && !wdCount_next[6])
				wdFire_reg <= 1'b1;
		end
	end

	// APB slave, one wait state
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= apbAccess;
			pslverr <= apbAccess & ~hitWdog & ~hitStat;
			if (apbAccess && !pwrite && hitWdog)
				prdata <= {24'h000000, wdRegView};
			else if (apbAccess && !pwrite && hitStat)
				prdata <= {28'h0000000, stopMode, nmiContext, wdEnabled, coreReset};
			else
				prdata <= 32'h00000000;
		end
	end

	// Core-facing outputs
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			coreTick <= 1'b0;
			wdogTick <= 1'b0;
			coreReset <= 1'b1;
			ioPullupInputs <= 1'b1;
			oscRun <= 1'b0;
			stackClear <= 1'b1;
			pcLoad <= `MRCW_RESET_VECTOR;
			nmiContext <= 1'b1;
			serviceInterrupt <= 1'b0;
			stopMode <= 1'b0;
			timerCtrl <= `MRCW_TIMER_CTRL_RST;
			timerCount <= `MRCW_TIMER_CNT_RST;
			timerPrescale <= `MRCW_TIMER_PRE_RST;
		end else begin
			coreTick <= coreTickW & (state_reg == ST_RUN);
			wdogTick <= wdogTickW;
			oscRun <= (state_reg != ST_OSC) | (osc_reg != 8'h00);
			serviceInterrupt <= 1'b0;
			if (state_next != ST_RUN) begin
				coreReset <= 1'b1;
				ioPullupInputs <= 1'b1;
				stackClear <= 1'b1;
				pcLoad <= `MRCW_RESET_VECTOR;
				nmiContext <= 1'b1;
				stopMode <= 1'b0;
				timerCtrl <= `MRCW_TIMER_CTRL_RST;
				timerCount <= `MRCW_TIMER_CNT_RST;
				timerPrescale <= `MRCW_TIMER_PRE_RST;
			end else begin
				coreReset <= 1'b0;
				ioPullupInputs <= 1'b0;
				stackClear <= 1'b0;
				if (returnFromInterrupt && coreMachineCycleDone && nmiContext) begin
					nmiContext <= 1'b0;
					serviceInterrupt <= interruptPending;
				end
				if (stopRequest && !wdEnabled)
					stopMode <= 1'b1;
				else if (wakeInterrupt)
					stopMode <= 1'b0;
			end
		end
	end
endmodule // mrcw_reset_clock_watchdog

// >>> sim/mrcw_sva.sv
// Checker for the reset, clock and watchdog block
`timescale 1ns/10ps
module mrcw_sva (
	// Clock, reset, pin
	input wire clk,
	input wire rst_b,
	input wire resetPin_b,
	input wire hwWatchdogOpt,
	// Bus
	input wire psel,
	input wire penable,
	input wire pready,
	// Outputs
	input wire coreTick,
	input wire wdogTick,
	input wire coreReset,
	input wire ioPullupInputs,
	input wire oscRun,
	input wire stackClear,
	input wire [11:0] pcLoad,
	input wire nmiContext,
	input wire stopMode,
	input wire [7:0] timerCtrl,
	input wire [7:0] timerCount,
	input wire [6:0] timerPrescale
);
	reg [3:0] wGap;
	reg [3:0] cGap;
	reg [11:0] rLen;
	reg wOk;
	reg cOk;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Gaps between ticks and length of each reset
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wGap <= 4'h0;
			cGap <= 4'h0;
			rLen <= 12'h000;
			wOk <= 1'b0;
			cOk <= 1'b0;
		end else begin
			wGap <= wdogTick ? 4'h0 : wGap + 4'h1;
			cGap <= coreTick ? 4'h0 : cGap + 4'h1;
			rLen <= !coreReset ? 12'h000 : rLen + {11'h000, ~&rLen};
			wOk <= !stopMode & (wOk | wdogTick);
			cOk <= !stopMode & !coreReset & (cOk | coreTick);
		end
	end
	chk_wdog_period: assert property (wdogTick && wOk |-> wGap == 4'hB)
		else $error("watchdog tick spacing wrong");
	chk_core_period: assert property (coreTick && cOk |-> cGap == 4'hC)
		else $error("core tick spacing wrong");
	chk_reset_vec: assert property (coreReset |-> pcLoad == 12'hFFE)
		else $error("reset vector wrong");
	chk_reset_io: assert property (coreReset |-> ioPullupInputs && stackClear)
		else $error("pull-ups or stack clear missing");
	chk_timer_rst: assert property (coreReset |-> timerCtrl == 8'h00 &&
		timerCount == 8'hFF && timerPrescale == 7'h7F)
		else $error("timer reset values wrong");
	chk_pin_hold: assert property (!resetPin_b [*4] |-> coreReset)
		else $error("pin low without reset");
	chk_stab_len: assert property ($fell(coreReset) |-> rLen[11])
		else $error("reset shorter than stabilisation");
	chk_nmi_start: assert property ($fell(coreReset) |-> nmiContext)
		else $error("core not in nmi context");
	chk_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("bus answer timing wrong");
	chk_hw_nostop: assert property (hwWatchdogOpt |-> !stopMode)
		else $error("stop under hardware watchdog");
	chk_osc_first: assert property (!oscRun |-> coreReset)
		else $error("core running without oscillator");
endmodule // mrcw_sva

// >>> sim/mrcw_ext_reset.sv
// External reset source driving the reset pin
`timescale 1ns/10ps
module mrcw_ext_reset (
	// Clock
	input wire clk,
	// Pin
	output reg resetPin_b
);
	initial resetPin_b = 1'b1;
	// Hold the pin low for n cycles
	task pulse(input integer n);
		begin
			resetPin_b <= 1'b0;
			repeat (n) @(posedge clk);
			resetPin_b <= 1'b1;
		end
	endtask
endmodule // mrcw_ext_reset

// >>> sim/test_mcu_reset_clock_watchdog.sv
// Testbench for the reset, clock and watchdog block
`timescale 1ns/10ps
module test_mcu_reset_clock_watchdog;
	reg clk, rst_b, hwWatchdogOpt, stopRequest, wakeInterrupt, rfi, intPend;
	reg psel, penable, pwrite, err;
	reg [7:0] paddr;
	reg [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, coreReset, nmiContext, serviceInterrupt, stopMode, resetPin_b;
	integer badCount = 0, samplesChecked = 0, n, svcCount = 0;
	mrcw_ext_reset ext (.clk(clk), .resetPin_b(resetPin_b));
	mrcw_reset_clock_watchdog dut (.clk, .rst_b, .resetPin_b, .hwWatchdogOpt, .stopRequest,
		.waitRequest(1'b0), .wakeInterrupt, .coreMachineCycleDone(rfi),
		.returnFromInterrupt(rfi), .interruptPending(intPend), .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .coreTick(), .wdogTick(), .coreReset,
		.ioPullupInputs(), .oscRun(), .stackClear(), .pcLoad(), .nmiContext,
		.serviceInterrupt, .stopMode, .timerCtrl(), .timerCount(), .timerPrescale());
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (serviceInterrupt) svcCount <= svcCount + 1;
	task check(input [8*6:1] name, input [31:0] seen, input [31:0] exp);
		begin
			samplesChecked = samplesChecked + 1;
			if (seen !== exp) begin
				badCount = badCount + 1;
				$display("mismatch %0s exp %h seen %h", name, exp, seen);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1)
				@(posedge clk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask
	task waitRun;
		begin
			for (n = 0; coreReset !== 1'b0 && n < 3000; n = n + 1)
				@(posedge clk);
			check("runup", n > 2040, 1);
			check("run", coreReset, 0);
		end
	endtask
	task resetCycle(input integer m);
		begin
			for (n = 0; coreReset !== 1'b1 && n < m; n = n + 1)
				@(posedge clk);
			check("reset", coreReset, 1);
		end
	endtask
	task closeOut;
		begin
			if (badCount == 0 && samplesChecked > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		#2000000;
		badCount = badCount + 1;
		closeOut;
	end
	initial begin
		{rst_b, hwWatchdogOpt, stopRequest, wakeInterrupt, rfi} = 5'h00;
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		intPend = 1'b1;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		apb(0, 8'hD8, 0);
		check("wdreg", rd, 32'hFE);
		waitRun;
		check("nmi", nmiContext, 1);
		rfi <= 1'b1;
		@(posedge clk);
		rfi <= 1'b0;
		repeat (8) @(posedge clk);
		check("nmi", nmiContext, 0);
		check("svc", svcCount, 1);
		apb(0, 8'h40, 0);
		check("err", err, 1);
		check("rdata", rd, 0);
		apb(1, 8'hD8, 32'h03);
		resetCycle(400);
		apb(0, 8'hD8, 0);
		check("wdreg", rd, 32'hFE);
		waitRun;
		apb(1, 8'hD8, 32'hFC);
		resetCycle(8);
		waitRun;
		intPend <= 1'b0;
		rfi <= 1'b1;
		@(posedge clk);
		rfi <= 1'b0;
		repeat (8) @(posedge clk);
		check("nmi", nmiContext, 0);
		check("svc", svcCount, 1);
		ext.pulse(2);
		resetCycle(8);
		waitRun;
		stopRequest <= 1'b1;
		repeat (4) @(posedge clk);
		check("stop", stopMode, 1);
		stopRequest <= 1'b0;
		wakeInterrupt <= 1'b1;
		repeat (4) @(posedge clk);
		check("stop", stopMode, 0);
		wakeInterrupt <= 1'b0;
		hwWatchdogOpt <= 1'b1;
		ext.pulse(3);
		resetCycle(8);
		waitRun;
		apb(0, 8'hD8, 0);
		check("act", rd[0], 1);
		stopRequest <= 1'b1;
		repeat (4) @(posedge clk);
		check("stop", stopMode, 0);
		closeOut;
	end
endmodule // test_mcu_reset_clock_watchdog
bind mrcw_reset_clock_watchdog mrcw_sva chk (.clk, .rst_b, .resetPin_b, .hwWatchdogOpt, .psel,
	.penable, .pready, .coreTick, .wdogTick, .coreReset, .ioPullupInputs, .oscRun, .stackClear,
	.pcLoad,
	.nmiContext, .stopMode, .timerCtrl, .timerCount, .timerPrescale);
